/* File: core/tmrx_cfg.svh */
// Constants for the timer 0/1 control and external interrupt flag block.
// Assumes inclusion by bare name from core/.
`ifndef TMRX_CFG_SVH
`define TMRX_CFG_SVH
`define TMRX_ADDR_MODE      8'h89
`define TMRX_ADDR_CTRL      8'h88
`define TMRX_ADDR_EXTCFG    8'he4
`define TMRX_RST_MODE       8'h00
`define TMRX_RST_CTRL       8'h00
`define TMRX_RST_EXTCFG     8'h01
`define TMRX_B_FLAG_TB_OVF  7
`define TMRX_B_RUN_TB       6
`define TMRX_B_FLAG_TA_OVF  5
`define TMRX_B_RUN_TA       4
`define TMRX_B_FLAG_EB      3
`define TMRX_B_EDGE_EB      2
`define TMRX_B_FLAG_EA      1
`define TMRX_B_EDGE_EA      0
`define TMRX_B_POL_A        3
`define TMRX_B_POL_B        7
`define TMRX_M_GATE_B       7
`define TMRX_M_SRC_B        6
`define TMRX_M_GATE_A       3
`define TMRX_M_SRC_A        2
`define TMRX_M_MODE_B_LO    4
`define TMRX_M_MODE_A_LO    0
`endif

/* File: core/tmrx_pkg.sv */
// Types for the timer 0/1 control block.
// Assumes tmrx_cfg.svh sits beside it.
package tmrx_pkg;
    typedef enum logic [1:0]
    {
        TMRX_MODE_13BIT = 2'b00,
        TMRX_MODE_16BIT = 2'b01,
        TMRX_MODE_8RELD = 2'b10,
        TMRX_MODE_SPLIT = 2'b11
    } tmrx_mode_t;
endpackage

/* File: core/tmrx_ext_if.sv */
// Interface between the top and one external interrupt channel.
// Assumes a single clock domain.
`timescale 1ns/1ps
interface tmrx_ext_if;
    logic pinSync;
    logic edgeSel;
    logic polHigh;
    logic swClear;
    logic vectorAck;
    logic flag;
    modport top (output pinSync, output edgeSel, output polHigh, output swClear,
                 output vectorAck, input flag);
    modport chan (input pinSync, input edgeSel, input polHigh, input swClear,
                  input vectorAck, output flag);
endinterface

/* File: core/tmrx_ext_chan.sv */
// One external interrupt flag channel: level or edge detection.
// Assumes pinSync is already synchronised to clk.
`timescale 1ns/1ps
module tmrx_ext_chan
(
    input  wire logic clk,
    input  wire logic resetn,
    tmrx_ext_if.chan  ch
);
    import tmrx_pkg::*;
    logic activeNow;
    logic prevReg;
    logic prevNext;
    logic flagReg;
    logic flagNext;

    always_comb
    begin
        activeNow = ch.pinSync ~^ ch.polHigh;
        prevNext  = activeNow;
        flagNext  = flagReg;
        if (!ch.edgeSel)
        begin
            flagNext = activeNow;
        end
        else
        begin
            if (ch.swClear || ch.vectorAck)
            begin
                flagNext = 1'b0;
            end
            if (activeNow && !prevReg)
            begin
                flagNext = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prevReg <= 1'b0;
            flagReg <= 1'b0;
        end
        else
        begin
            prevReg <= prevNext;
            flagReg <= flagNext;
        end
    end

    assign ch.flag = flagReg;
endmodule

/* File: core/tmrx_ctrl.sv */
// Timer 0/1 mode and control registers with external interrupt flags.
// Assumes an SFR port on clk; count datapaths sit outside.
// Operation
// - Each external input has an edge-select bit: 0 means level, 1 means edge.
// - Active polarity of each input comes from its own bit in the config register.
// - Hardware sets flag A when the selected edge or level is seen on line A.
// - In edge mode software clears flag A, and vectoring clears it too.
// - In level mode flag A reads 1 while line A is at its active level.
// - Input B flag behaves exactly like input A.
// - Overflow flags set on overflow, clear by software or on vectoring.
`timescale 1ns/1ps
`include "tmrx_cfg.svh"
module tmrx_ctrl
(
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic [7:0]         sfrAddr,
    input  wire logic [7:0]         sfrWdata,
    input  wire logic               sfrWrite,
    input  wire logic               sfrRead,
    output logic [7:0]              sfrRdata,
    input  wire logic               extLineA_n,
    input  wire logic               extLineB_n,
    input  wire logic               timerAOverflow,
    input  wire logic               timerBOverflow,
    input  wire logic               vectorExtA,
    input  wire logic               vectorExtB,
    input  wire logic               vectorTimerA,
    input  wire logic               vectorTimerB,
    output logic                    timerARun,
    output logic                    timerBRun,
    output logic                    timerAGateOpen,
    output logic                    timerBGateOpen,
    output logic                    timerACountPin,
    output logic                    timerBCountPin,
    output tmrx_pkg::tmrx_mode_t    timerAMode,
    output tmrx_pkg::tmrx_mode_t    timerBMode,
    output logic                    extIrqA,
    output logic                    extIrqB
);
    import tmrx_pkg::*;

    // ----------------------------------------
    // Line synchronisers
    // ----------------------------------------
    logic [2:0] syncA_reg;
    logic [2:0] syncB_reg;
    logic [2:0] syncA_next;
    logic [2:0] syncB_next;
    logic       stableA_reg;
    logic       stableB_reg;
    logic       stableA_next;
    logic       stableB_next;

    always_comb
    begin
        syncA_next   = {syncA_reg[1:0], extLineA_n};
        syncB_next   = {syncB_reg[1:0], extLineB_n};
        stableA_next = (syncA_reg[1] == syncA_reg[2]) ? syncA_reg[2] : stableA_reg;
        stableB_next = (syncB_reg[1] == syncB_reg[2]) ? syncB_reg[2] : stableB_reg;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            syncA_reg   <= 3'h7;
            syncB_reg   <= 3'h7;
            stableA_reg <= 1'b1;
            stableB_reg <= 1'b1;
        end
        else
        begin
            syncA_reg   <= syncA_next;
            syncB_reg   <= syncB_next;
            stableA_reg <= stableA_next;
            stableB_reg <= stableB_next;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] timer_mode_config_reg;
    logic [7:0] timer_mode_config_next;
    logic [7:0] timer_irq_control_reg;
    logic [7:0] timer_irq_control_next;
    logic [7:0] external_irq_config_reg;
    logic [7:0] external_irq_config_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       wrCtrl;
    logic       flagA;
    logic       flagB;

    tmrx_ext_if chA ();
    tmrx_ext_if chB ();

    assign wrCtrl = sfrWrite && (sfrAddr == `TMRX_ADDR_CTRL);

    assign chA.pinSync   = stableA_reg;
    assign chA.edgeSel   = timer_irq_control_reg[`TMRX_B_EDGE_EA];
    assign chA.polHigh   = external_irq_config_reg[`TMRX_B_POL_A];
    assign chA.swClear   = wrCtrl && !sfrWdata[`TMRX_B_FLAG_EA];
    assign chA.vectorAck = vectorExtA;
    assign flagA         = chA.flag;
    assign chB.pinSync   = stableB_reg;
    assign chB.edgeSel   = timer_irq_control_reg[`TMRX_B_EDGE_EB];
    assign chB.polHigh   = external_irq_config_reg[`TMRX_B_POL_B];
    assign chB.swClear   = wrCtrl && !sfrWdata[`TMRX_B_FLAG_EB];
    assign chB.vectorAck = vectorExtB;
    assign flagB         = chB.flag;

    tmrx_ext_chan uChanA
    (
        .clk    (clk),
        .resetn (resetn),
        .ch     (chA)
    );

    tmrx_ext_chan uChanB
    (
        .clk    (clk),
        .resetn (resetn),
        .ch     (chB)
    );

    always_comb
    begin
        timer_mode_config_next   = timer_mode_config_reg;
        external_irq_config_next = external_irq_config_reg;
        timer_irq_control_next   = timer_irq_control_reg;
        if (sfrWrite && (sfrAddr == `TMRX_ADDR_MODE))
        begin
            timer_mode_config_next = sfrWdata;
        end
        if (sfrWrite && (sfrAddr == `TMRX_ADDR_EXTCFG))
        begin
            external_irq_config_next = sfrWdata;
        end
        if (wrCtrl)
        begin
            timer_irq_control_next = sfrWdata;
        end
        // Vectoring clears, hardware overflow set wins over any clear
        if (vectorTimerA)
        begin
            timer_irq_control_next[`TMRX_B_FLAG_TA_OVF] = 1'b0;
        end
        if (vectorTimerB)
        begin
            timer_irq_control_next[`TMRX_B_FLAG_TB_OVF] = 1'b0;
        end
        if (timerAOverflow)
        begin
            timer_irq_control_next[`TMRX_B_FLAG_TA_OVF] = 1'b1;
        end
        if (timerBOverflow)
        begin
            timer_irq_control_next[`TMRX_B_FLAG_TB_OVF] = 1'b1;
        end
        // External flags live in the channels
        timer_irq_control_next[`TMRX_B_FLAG_EA] = 1'b0;
        timer_irq_control_next[`TMRX_B_FLAG_EB] = 1'b0;
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb
    begin
        rdata_next = rdata_reg;
        if (sfrRead)
        begin
            case (sfrAddr)
                `TMRX_ADDR_MODE:   rdata_next = timer_mode_config_reg;
                `TMRX_ADDR_EXTCFG: rdata_next = external_irq_config_reg;
                `TMRX_ADDR_CTRL:
                begin
                    rdata_next = timer_irq_control_reg;
                    rdata_next[`TMRX_B_FLAG_EA] = flagA;
                    rdata_next[`TMRX_B_FLAG_EB] = flagB;
                end
                default:           rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            timer_mode_config_reg   <= `TMRX_RST_MODE;
            timer_irq_control_reg   <= `TMRX_RST_CTRL;
            external_irq_config_reg <= `TMRX_RST_EXTCFG;
            rdata_reg               <= 8'h00;
        end
        else
        begin
            timer_mode_config_reg   <= timer_mode_config_next;
            timer_irq_control_reg   <= timer_irq_control_next;
            external_irq_config_reg <= external_irq_config_next;
            rdata_reg               <= rdata_next;
        end
    end

    // ----------------------------------------
    // Registered outputs to the count datapaths
    // ----------------------------------------
    logic       outRunA_next;
    logic       outRunB_next;
    logic       outGateA_next;
    logic       outGateB_next;
    tmrx_mode_t outModeA_next;
    tmrx_mode_t outModeB_next;

    always_comb
    begin
        outRunA_next  = timer_irq_control_next[`TMRX_B_RUN_TA];
        outRunB_next  = timer_irq_control_next[`TMRX_B_RUN_TB];
        // Gate open when pin gating is off or the line is at its active level
        outGateA_next = !timer_mode_config_next[`TMRX_M_GATE_A] ||
                        (stableA_next ~^ external_irq_config_next[`TMRX_B_POL_A]);
        outGateB_next = !timer_mode_config_next[`TMRX_M_GATE_B] ||
                        (stableB_next ~^ external_irq_config_next[`TMRX_B_POL_B]);
        outModeA_next = tmrx_mode_t'(timer_mode_config_next[`TMRX_M_MODE_A_LO +: 2]);
        outModeB_next = tmrx_mode_t'(timer_mode_config_next[`TMRX_M_MODE_B_LO +: 2]);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            timerARun      <= 1'b0;
            timerBRun      <= 1'b0;
            timerAGateOpen <= 1'b1;
            timerBGateOpen <= 1'b1;
            timerACountPin <= 1'b0;
            timerBCountPin <= 1'b0;
            timerAMode     <= TMRX_MODE_13BIT;
            timerBMode     <= TMRX_MODE_13BIT;
            extIrqA        <= 1'b0;
            extIrqB        <= 1'b0;
            sfrRdata       <= 8'h00;
        end
        else
        begin
            timerARun      <= outRunA_next;
            timerBRun      <= outRunB_next;
            timerAGateOpen <= outGateA_next;
            timerBGateOpen <= outGateB_next;
            timerACountPin <= timer_mode_config_next[`TMRX_M_SRC_A];
            timerBCountPin <= timer_mode_config_next[`TMRX_M_SRC_B];
            timerAMode     <= outModeA_next;
            timerBMode     <= outModeB_next;
            extIrqA        <= flagA;
            extIrqB        <= flagB;
            sfrRdata       <= rdata_next;
        end
    end
endmodule

/* File: test/tmrx_pin_model.sv */
// Model of the two external interrupt pins.
// Assumes the bench sets the wanted levels; pins are not tied to clk.
`timescale 1ns/1ps
module tmrx_pin_model
(
    input  wire logic wantA,
    input  wire logic wantB,
    output logic      lineA_n,
    output logic      lineB_n
);
    // Pins move off the clock grid so the synchroniser sees real skew
    assign #3 lineA_n = wantA;
    assign #3 lineB_n = wantB;
endmodule

/* File: test/tmrx_ctrl_sva.sv */
// Checker for tmrx_ctrl, bound to every instance below.
// Assumes one clock and the SFR map of tmrx_cfg.svh.
`timescale 1ns/1ps
module tmrx_ctrl_sva
(
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire logic [7:0]           sfrAddr,
    input wire logic [7:0]           sfrWdata,
    input wire logic                 sfrWrite,
    input wire logic                 sfrRead,
    input wire logic [7:0]           sfrRdata,
    input wire logic                 extLineA_n,
    input wire logic                 extLineB_n,
    input wire logic                 timerAOverflow,
    input wire logic                 vectorExtA,
    input wire logic                 vectorTimerA,
    input wire tmrx_pkg::tmrx_mode_t timerAMode,
    input wire tmrx_pkg::tmrx_mode_t timerBMode,
    input wire logic                 extIrqA,
    input wire logic                 extIrqB
);
    import tmrx_pkg::*;
    logic edgeA_reg, edgeB_reg, polA_reg, polB_reg, cfgOk_reg;
    logic wrCtl, rdCtl, actA, actB;
    // -----------------------------------------
    // Shadow of edge and polarity settings
    // -----------------------------------------
    assign wrCtl = sfrWrite && sfrAddr == 8'h88;
    assign rdCtl = sfrRead && sfrAddr == 8'h88;
    assign actA  = cfgOk_reg && extLineA_n == polA_reg;
    assign actB  = cfgOk_reg && extLineB_n == polB_reg;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            {edgeA_reg, edgeB_reg, polA_reg, polB_reg, cfgOk_reg} <= 5'h00;
        else if (wrCtl)
            {edgeB_reg, edgeA_reg} <= {sfrWdata[2], sfrWdata[0]};
        else if (sfrWrite && sfrAddr == 8'he4)
            {polB_reg, polA_reg, cfgOk_reg} <= {sfrWdata[7], sfrWdata[3], 1'b1};
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    property p_mode_wr; sfrWrite && sfrAddr == 8'h89 |=> {timerBMode, timerAMode} ==
        {$past(sfrWdata[5:4]), $past(sfrWdata[1:0])}; endproperty
    a_mode_wr: assert property (p_mode_wr) else $error("mode field not loaded");
    property p_ovf_set; timerAOverflow ##1 !(vectorTimerA || wrCtl) ##1
        rdCtl && !(vectorTimerA || wrCtl) |=> sfrRdata[5]; endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag A not set");
    property p_lvl_a; (!edgeA_reg && actA) [*8] |-> extIrqA; endproperty
    a_lvl_a: assert property (p_lvl_a) else $error("level flag A low");
    property p_off_a; (cfgOk_reg && !edgeA_reg && !actA) [*8] |-> !extIrqA; endproperty
    a_off_a: assert property (p_off_a) else $error("level flag A high");
    property p_edge_a; edgeA_reg && $rose(actA) |-> ##[1:8] extIrqA; endproperty
    a_edge_a: assert property (p_edge_a) else $error("edge flag A not set");
    property p_clr_a; (edgeA_reg && $stable(extLineA_n)) [*6] ##0
        (vectorExtA || wrCtl && !sfrWdata[1]) |-> ##[1:3] !extIrqA; endproperty
    a_clr_a: assert property (p_clr_a) else $error("edge flag A not cleared");
    property p_lvl_b; (!edgeB_reg && actB) [*8] |-> extIrqB; endproperty
    a_lvl_b: assert property (p_lvl_b) else $error("level flag B low");
    property p_edge_b; edgeB_reg && $rose(actB) |-> ##[1:8] extIrqB; endproperty
    a_edge_b: assert property (p_edge_b) else $error("edge flag B not set");
    c_ovf: cover property (rdCtl && !timerAOverflow ##1 sfrRdata[5]);
    c_edge_a: cover property (edgeA_reg && extIrqA);
    c_lvl_b: cover property (!edgeB_reg && extIrqB);
endmodule
bind tmrx_ctrl tmrx_ctrl_sva i_tmrx_ctrl_sva
(
    .clk(clk), .resetn(resetn), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrRdata(sfrRdata),
    .extLineA_n(extLineA_n), .extLineB_n(extLineB_n), .timerAOverflow(timerAOverflow),
    .vectorExtA(vectorExtA), .vectorTimerA(vectorTimerA), .timerAMode(timerAMode),
    .timerBMode(timerBMode), .extIrqA(extIrqA), .extIrqB(extIrqB)
);

/* File: test/testbench.sv */
// Bench for tmrx_ctrl: SFR tasks, pin model, self-checking sequence.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
module testbench;
    import tmrx_pkg::*;
    logic       clk, resetn, sfrWrite, sfrRead;
    logic [7:0] sfrAddr, sfrWdata, sfrRdata;
    logic [5:0] pulses;
    logic       wantA, wantB, lineA_n, lineB_n, cntA, cntB, irqA, irqB;
    logic       runA, runB, gateA, gateB;
    tmrx_mode_t modeA, modeB;
    int         err_count, num_checks, cycles;
    tmrx_ctrl i_tmrx_ctrl
    (
        .clk(clk), .resetn(resetn), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
        .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrRdata(sfrRdata),
        .extLineA_n(lineA_n), .extLineB_n(lineB_n),
        .timerAOverflow(pulses[0]), .timerBOverflow(pulses[1]),
        .vectorExtA(pulses[2]), .vectorExtB(pulses[3]),
        .vectorTimerA(pulses[4]), .vectorTimerB(pulses[5]),
        .timerARun(runA), .timerBRun(runB), .timerAGateOpen(gateA), .timerBGateOpen(gateB),
        .timerACountPin(cntA), .timerBCountPin(cntB), .timerAMode(modeA),
        .timerBMode(modeB), .extIrqA(irqA), .extIrqB(irqB)
    );
    tmrx_pin_model i_tmrx_pin_model
    (
        .wantA(wantA), .wantB(wantB), .lineA_n(lineA_n), .lineB_n(lineB_n)
    );
    // -----------------------------------------
    // Access tasks
    // -----------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {sfrAddr, sfrWdata, sfrWrite} <= {a, d, 1'b1};
        @(posedge clk);
        sfrWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        {sfrAddr, sfrRead} <= {a, 1'b1};
        @(posedge clk);
        sfrRead <= 1'b0;
        wt(1);
        chk(sfrRdata, exp);
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        pulses[i] <= 1'b1;
        @(posedge clk);
        pulses[i] <= 1'b0;
    endtask
    task automatic pin(input logic a, input logic b);
        @(posedge clk);
        {wantA, wantB} <= {a, b};
        wt(10);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            end_sim();
        end
    end
    // -----------------------------------------
    // Test sequence
    // -----------------------------------------
    initial
    begin
        logic [7:0] d;
        {resetn, sfrWrite, sfrRead, sfrAddr, sfrWdata, pulses} = '0;
        {wantA, wantB, err_count, num_checks, cycles} = '1;
        {err_count, num_checks, cycles} = '0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h88, 8'h00);
        rd(8'h89, 8'h00);
        rd(8'he4, 8'h01);
        rd(8'h55, 8'h00);
        $display("test reset done");
        for (int m = 0; m < 4; m++)
        begin
            d = {2'b01, 2'(m), 2'b00, 2'(3 - m)};
            wr(8'h89, d);
            wt(1);
            chk({2'h0, cntB, cntA, modeB, modeA}, {4'h2, d[5:4], d[1:0]});
            rd(8'h89, d);
        end
        $display("test modes done");
        pulse(0);
        rd(8'h88, 8'h20);
        pulse(4);
        rd(8'h88, 8'h00);
        pulse(1);
        rd(8'h88, 8'h80);
        pulse(5);
        rd(8'h88, 8'h00);
        pulse(0);
        wr(8'h88, 8'h00);
        rd(8'h88, 8'h00);
        $display("test overflow done");
        wr(8'he4, 8'h08);
        pin(1, 1);
        chk({7'h0, irqA}, 8'h01);
        rd(8'h88, 8'h02);
        pin(0, 1);
        chk({7'h0, irqA}, 8'h00);
        wr(8'he4, 8'h00);
        wt(10);
        chk({7'h0, irqA}, 8'h01);
        $display("test level done");
        pin(1, 1);
        wr(8'h88, 8'h01);
        pin(0, 1);
        chk({7'h0, irqA}, 8'h01);
        pin(1, 1);
        chk({7'h0, irqA}, 8'h01);
        wr(8'h88, 8'h01);
        wt(4);
        chk({7'h0, irqA}, 8'h00);
        pin(0, 1);
        chk({7'h0, irqA}, 8'h01);
        pulse(2);
        wt(4);
        chk({7'h0, irqA}, 8'h00);
        $display("test edge done");
        wr(8'h88, 8'h04);
        pin(1, 0);
        chk({7'h0, irqB}, 8'h01);
        pulse(3);
        wt(4);
        chk({7'h0, irqB}, 8'h00);
        wr(8'h88, 8'h00);
        wt(10);
        rd(8'h88, 8'h08);
        $display("test input b done");
        wr(8'h89, 8'h88);
        wr(8'h88, 8'h50);
        wt(1);
        chk({4'h0, runB, runA, gateB, gateA}, 8'h0e);
        rd(8'h88, 8'h58);
        pin(0, 1);
        chk({4'h0, runB, runA, gateB, gateA}, 8'h0d);
        rd(8'h88, 8'h52);
        $display("test run and gate done");
        end_sim();
    end
endmodule
